// >>> common/mpt_pkg.sv
package mpt_pkg;

    // ==========================================================
    // Clock and bit timing.
    localparam int CLK_NS      = 8;
    localparam int BIT100_NS   = 10;
    localparam int BIT10_NS    = 100;
    localparam int STAMP_W     = 10;
    localparam int FIFO_DEPTH  = 16;
    localparam int TX_PIPE_CYC = 4;
    localparam int RX_PIPE_CYC = 2;

    // ==========================================================
    // Latencies in tenths of a bit time.
    localparam int TX_LAT100_BX10 = 60;
    localparam int TX_LAT10_BX10  = 35;
    localparam int CRS_ON_BX10    = 200;
    localparam int RX_DATA_BX10   = 240;
    localparam int CRS_OFF_BX10   = 240;

    // ==========================================================
    // Receive clock phases in nanoseconds.
    localparam int HALF_HI100_NS  = 24;
    localparam int HALF_LO100_NS  = 16;
    localparam int HALF10_NS      = 200;
    localparam int MIN_HALF100_NS = 16;
    localparam int MIN_HALF10_NS  = 160;

    function automatic int lat_cyc(input int bx10, input int bit_ns, input int pipe);
        return (bx10 * bit_ns / 10 + CLK_NS / 2) / CLK_NS - pipe;
    endfunction

    function automatic int ceil_cyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    localparam logic [STAMP_W-1:0] TX_LAT100_CYC  = STAMP_W'(lat_cyc(TX_LAT100_BX10, BIT100_NS, TX_PIPE_CYC));
    localparam logic [STAMP_W-1:0] TX_LAT10_CYC   = STAMP_W'(lat_cyc(TX_LAT10_BX10, BIT10_NS, TX_PIPE_CYC));
    localparam logic [STAMP_W-1:0] CRS_ON100_CYC  = STAMP_W'(lat_cyc(CRS_ON_BX10, BIT100_NS, 0));
    localparam logic [STAMP_W-1:0] CRS_ON10_CYC   = STAMP_W'(lat_cyc(CRS_ON_BX10, BIT10_NS, 0));
    localparam logic [STAMP_W-1:0] RXD100_CYC     = STAMP_W'(lat_cyc(RX_DATA_BX10, BIT100_NS, RX_PIPE_CYC));
    localparam logic [STAMP_W-1:0] RXD10_CYC      = STAMP_W'(lat_cyc(RX_DATA_BX10, BIT10_NS, RX_PIPE_CYC));
    localparam logic [STAMP_W-1:0] CRS_OFF100_CYC = STAMP_W'(lat_cyc(CRS_OFF_BX10, BIT100_NS, 0));
    localparam logic [STAMP_W-1:0] CRS_OFF10_CYC  = STAMP_W'(lat_cyc(CRS_OFF_BX10, BIT10_NS, 0));
    localparam logic [5:0]         HALF_HI100_CYC = 6'(HALF_HI100_NS / CLK_NS);
    localparam logic [5:0]         HALF_LO100_CYC = 6'(HALF_LO100_NS / CLK_NS);
    localparam logic [5:0]         HALF10_CYC     = 6'(HALF10_NS / CLK_NS);
    localparam logic [6:0]         MIN_HALF100_CYC = 7'(ceil_cyc(MIN_HALF100_NS));
    localparam logic [6:0]         MIN_HALF10_CYC  = 7'(ceil_cyc(MIN_HALF10_NS));

endpackage

// >>> rtl/mpt_fifo.sv
`timescale 1ns/1ns
module mpt_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic [AW:0]   count_next;
    logic          in_ready_reg;
    logic          out_valid_reg;
    logic [W-1:0]  out_data_reg;

    wire push = in_valid & in_ready_reg;
    wire load = (count_reg != '0) & (~out_valid_reg | out_ready);

    assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    assign in_ready   = in_ready_reg;
    assign out_valid  = out_valid_reg;
    assign out_data   = out_data_reg;

    // ==========================================================
    // Storage and registered read port.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
        if (load) begin
            out_data_reg <= mem_reg[rd_ptr_reg];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            in_ready_reg  <= 1'b1;
            out_valid_reg <= 1'b0;
        end else begin
            wr_ptr_reg    <= wr_ptr_reg + AW'(push);
            rd_ptr_reg    <= rd_ptr_reg + AW'(load);
            count_reg     <= count_next;
            in_ready_reg  <= count_next < (AW+1)'(DEPTH);
            out_valid_reg <= load | (out_valid_reg & ~out_ready);
        end
    end
endmodule

// >>> rtl/mpt_mii_pmd_timing.sv
// What this block does
// RQ1: At 100 Mb/s the start delimiter leaves about 6 bits after the sampling edge.
// RQ2: At 100 Mb/s the end delimiter leaves about 6 bits after enable drops.
// RQ3: Carrier sense rises 20 bits after start; receive data appear 24 bits late.
// RQ4: Carrier sense falls about 24 bits after the incoming end delimiter.
// RQ5: At 10 Mb/s transmit inputs are sampled on the falling transmit clock edge.
// RQ6: The MAC launches transmit data on the rising transmit clock edge.
// RQ7: Switching the receive clock source may stretch a phase, never shorten one.
// RQ8: At 10 Mb/s the line output starts 3.5 bits after the sampling edge.
// RQ9: Bit times are 10 ns and 100 ns; clock half periods near 20/200 ns.
// RQ10: Data cross the interface as one nibble per interface clock cycle.
`timescale 1ns/1ns
module mpt_mii_pmd_timing (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       speed_100,
    input  wire logic       tx_clk,
    input  wire logic       tx_en,
    input  wire logic [3:0] txd,
    input  wire logic       pmd_tx_ready,
    output logic            pmd_tx_valid,
    output logic [3:0]      pmd_txd,
    output logic            pmd_tx_sos,
    output logic            pmd_tx_eos,
    output logic            tx_fifo_ready,
    input  wire logic       pmd_rx_valid,
    input  wire logic [3:0] pmd_rxd,
    input  wire logic       pmd_rx_sos,
    input  wire logic       pmd_rx_eos,
    input  wire logic       rx_src_recovered,
    output logic            pmd_rx_ready,
    output logic            rx_clk,
    output logic            rx_dv,
    output logic [3:0]      rxd,
    output logic            crs
);
    localparam int SW = mpt_pkg::STAMP_W;

    function automatic logic [SW-1:0] age_of(input logic [SW-1:0] now, input logic [SW-1:0] stamp);
        return now - stamp;
    endfunction

    function automatic logic [5:0] half_len(input logic fast, input logic level);
        return fast ? (level ? mpt_pkg::HALF_HI100_CYC : mpt_pkg::HALF_LO100_CYC) : mpt_pkg::HALF10_CYC;
    endfunction

    // ==========================================================
    // Pin synchronisers and transmit clock edges.
    logic          speed_s1_reg, speed_s2_reg;
    logic          tx_clk_s1_reg, tx_clk_s2_reg, tx_clk_s3_reg;
    logic          tx_en_s1_reg, tx_en_s2_reg, tx_en_s3_reg;
    logic [3:0]    txd_s1_reg, txd_s2_reg, txd_s3_reg;
    logic          tx_last_en_reg;
    logic [SW-1:0] now_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_s1_reg  <= 1'b1;
            speed_s2_reg  <= 1'b1;
            tx_clk_s1_reg <= 1'b0;
            tx_clk_s2_reg <= 1'b0;
            tx_clk_s3_reg <= 1'b0;
            tx_en_s1_reg  <= 1'b0;
            tx_en_s2_reg  <= 1'b0;
            txd_s1_reg    <= 4'h0;
            txd_s2_reg    <= 4'h0;
            tx_en_s3_reg  <= 1'b0;
            txd_s3_reg    <= 4'h0;
        end else begin
            speed_s1_reg  <= speed_100;
            speed_s2_reg  <= speed_s1_reg;
            tx_clk_s1_reg <= tx_clk;
            tx_clk_s2_reg <= tx_clk_s1_reg;
            tx_clk_s3_reg <= tx_clk_s2_reg;
            tx_en_s1_reg  <= tx_en;
            tx_en_s2_reg  <= tx_en_s1_reg;
            txd_s1_reg    <= txd;
            txd_s2_reg    <= txd_s1_reg;
            tx_en_s3_reg  <= tx_en_s2_reg;
            txd_s3_reg    <= txd_s2_reg;
        end
    end

    wire tx_rise   = tx_clk_s2_reg & ~tx_clk_s3_reg;
    wire tx_fall   = ~tx_clk_s2_reg & tx_clk_s3_reg;
    wire tx_sample = speed_s2_reg ? tx_rise : tx_fall; // RQ1 RQ5 RQ6
    wire tx_en_smp = speed_s2_reg ? tx_en_s3_reg : tx_en_s2_reg; // RQ1 RQ2
    wire [3:0] txd_smp = speed_s2_reg ? txd_s3_reg : txd_s2_reg;
    wire tx_push   = tx_sample & (tx_en_smp | tx_last_en_reg);
    wire tx_start  = tx_sample & tx_en_smp & ~tx_last_en_reg;
    wire tx_end    = tx_sample & ~tx_en_smp & tx_last_en_reg;

    // ==========================================================
    // Transmit path: each nibble carries its sampling time stamp.
    logic          tx_out_valid;
    logic [SW+4:0] tx_out_data;
    logic          tx_drain_en_reg;
    logic          tx_pop;
    logic          pmd_tx_valid_reg, pmd_tx_sos_reg, pmd_tx_eos_reg;
    logic [3:0]    pmd_txd_reg;

    mpt_fifo #(.W(SW + 5), .DEPTH(mpt_pkg::FIFO_DEPTH)) u_tx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (tx_push),
        .in_ready  (tx_fifo_ready),
        .in_data   ({tx_en_smp, txd_smp, now_reg}),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_out_data)
    );

    wire [SW-1:0] tx_lat  = speed_s2_reg ? mpt_pkg::TX_LAT100_CYC : mpt_pkg::TX_LAT10_CYC; // RQ1 RQ2 RQ8 RQ9
    wire          tx_aged = tx_out_valid & (age_of(now_reg, tx_out_data[SW-1:0]) >= tx_lat);
    assign tx_pop = tx_aged & pmd_tx_ready;
    wire          tx_h_en = tx_out_data[SW+4];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            now_reg          <= '0;
            tx_last_en_reg   <= 1'b0;
            tx_drain_en_reg  <= 1'b0;
            pmd_tx_valid_reg <= 1'b0;
            pmd_tx_sos_reg   <= 1'b0;
            pmd_tx_eos_reg   <= 1'b0;
            pmd_txd_reg      <= 4'h0;
        end else begin
            now_reg          <= now_reg + SW'(1);
            tx_last_en_reg   <= tx_sample ? tx_en_smp : tx_last_en_reg;
            tx_drain_en_reg  <= tx_pop ? tx_h_en : tx_drain_en_reg;
            pmd_tx_valid_reg <= tx_pop & tx_h_en; // RQ10
            pmd_tx_sos_reg   <= tx_pop & tx_h_en & ~tx_drain_en_reg; // RQ1 RQ8
            pmd_tx_eos_reg   <= tx_pop & ~tx_h_en & tx_drain_en_reg; // RQ2
            pmd_txd_reg      <= tx_pop ? tx_out_data[SW+3:SW] : pmd_txd_reg;
        end
    end

    assign pmd_tx_valid = pmd_tx_valid_reg;
    assign pmd_tx_sos   = pmd_tx_sos_reg;
    assign pmd_tx_eos   = pmd_tx_eos_reg;
    assign pmd_txd      = pmd_txd_reg;

    // ==========================================================
    // Receive clock generator; a source or speed change stretches a phase.
    logic [5:0] rx_phase_cnt_reg;
    logic [1:0] rx_mode_reg;
    logic       rx_clk_reg;
    logic [6:0] rx_run_reg;

    wire [1:0] rx_mode_now = {speed_s2_reg, rx_src_recovered};
    wire       rx_mode_chg = rx_mode_now != rx_mode_reg;
    wire       phase_end   = rx_phase_cnt_reg == 6'h01;
    wire       rx_rise     = phase_end & ~rx_clk_reg;
    wire [5:0] rx_len      = half_len(speed_s2_reg, ~rx_clk_reg);
    wire [5:0] rx_len_next = rx_mode_chg ? rx_len + rx_len : rx_len; // RQ7

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_phase_cnt_reg <= mpt_pkg::HALF_LO100_CYC;
            rx_mode_reg      <= 2'h2;
            rx_clk_reg       <= 1'b0;
            rx_run_reg       <= 7'h00;
        end else begin
            rx_phase_cnt_reg <= phase_end ? rx_len_next : rx_phase_cnt_reg - 6'h01;
            rx_mode_reg      <= phase_end ? rx_mode_now : rx_mode_reg;
            rx_clk_reg       <= rx_clk_reg ^ phase_end;
            rx_run_reg       <= phase_end ? 7'h00 : rx_run_reg + 7'h01;
        end
    end

    // ==========================================================
    // Receive data delay and carrier sense.
    logic          rx_out_valid;
    logic [SW+3:0] rx_out_data;
    logic          rx_dv_reg, crs_reg;
    logic [3:0]    rxd_reg;
    logic [SW-1:0] crs_on_cnt_reg, crs_off_cnt_reg;
    logic          rx_pop;

    mpt_fifo #(.W(SW + 4), .DEPTH(mpt_pkg::FIFO_DEPTH)) u_rx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (pmd_rx_valid),
        .in_ready  (pmd_rx_ready),
        .in_data   ({pmd_rxd, now_reg}),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out_data)
    );

    wire [SW-1:0] rx_lat  = speed_s2_reg ? mpt_pkg::RXD100_CYC : mpt_pkg::RXD10_CYC;
    wire          rx_aged = rx_out_valid & (age_of(now_reg, rx_out_data[SW-1:0]) >= rx_lat); // RQ3
    assign rx_pop = rx_rise & rx_aged; // RQ10
    wire [SW-1:0] crs_on  = speed_s2_reg ? mpt_pkg::CRS_ON100_CYC : mpt_pkg::CRS_ON10_CYC;
    wire [SW-1:0] crs_off = speed_s2_reg ? mpt_pkg::CRS_OFF100_CYC : mpt_pkg::CRS_OFF10_CYC;
    wire          crs_set = crs_on_cnt_reg == SW'(1);
    wire          crs_clr = crs_off_cnt_reg == SW'(1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_dv_reg       <= 1'b0;
            rxd_reg         <= 4'h0;
            crs_reg         <= 1'b0;
            crs_on_cnt_reg  <= '0;
            crs_off_cnt_reg <= '0;
        end else begin
            rx_dv_reg       <= rx_rise ? rx_aged : rx_dv_reg;
            rxd_reg         <= rx_pop ? rx_out_data[SW+3:SW] : rxd_reg;
            crs_on_cnt_reg  <= pmd_rx_sos ? crs_on : crs_on_cnt_reg - SW'(crs_on_cnt_reg != '0); // RQ3
            crs_off_cnt_reg <= pmd_rx_eos ? crs_off : crs_off_cnt_reg - SW'(crs_off_cnt_reg != '0); // RQ4
            crs_reg         <= crs_set | (crs_reg & ~crs_clr);
        end
    end

    assign rx_clk = rx_clk_reg;
    assign rx_dv  = rx_dv_reg;
    assign rxd    = rxd_reg;
    assign crs    = crs_reg;

    // ==========================================================
    // Assertions and cover points.
    localparam int TXA100_LO = int'(mpt_pkg::TX_LAT100_CYC) + 1;
    localparam int TXA100_HI = int'(mpt_pkg::TX_LAT100_CYC) + 3;
    localparam int TXA10_LO  = int'(mpt_pkg::TX_LAT10_CYC) + 1;
    localparam int TXA10_HI  = int'(mpt_pkg::TX_LAT10_CYC) + 3;
    localparam int CRSA_ON   = int'(mpt_pkg::CRS_ON100_CYC) + 1;
    localparam int CRSA_OFF  = int'(mpt_pkg::CRS_OFF100_CYC) + 1;
    localparam int RXA_LO    = int'(mpt_pkg::RXD100_CYC) + 1;
    localparam int RXA_HI    = int'(mpt_pkg::RXD100_CYC) + 6;

    property p_tx_sos100;
        @(posedge clk) disable iff (!rst_n)
        tx_start && speed_s2_reg && pmd_tx_ready |-> ##[TXA100_LO:TXA100_HI] pmd_tx_sos_reg;
    endproperty
    a_tx_sos100: assert property (p_tx_sos100) else $error("start delimiter late at 100 Mb/s"); // RQ1

    property p_tx_eos100;
        @(posedge clk) disable iff (!rst_n)
        tx_end && speed_s2_reg && pmd_tx_ready |-> ##[TXA100_LO:TXA100_HI] pmd_tx_eos_reg;
    endproperty
    a_tx_eos100: assert property (p_tx_eos100) else $error("end delimiter late at 100 Mb/s"); // RQ2

    property p_tx_sos10;
        @(posedge clk) disable iff (!rst_n)
        tx_start && !speed_s2_reg && pmd_tx_ready |-> ##[TXA10_LO:TXA10_HI] pmd_tx_sos_reg;
    endproperty
    a_tx_sos10: assert property (p_tx_sos10) else $error("line output late at 10 Mb/s"); // RQ8

    property p_tx_fall10;
        @(posedge clk) disable iff (!rst_n)
        tx_push && !speed_s2_reg |-> !tx_clk_s2_reg && $past(tx_clk_s2_reg);
    endproperty
    a_tx_fall10: assert property (p_tx_fall10) else $error("10 Mb/s sample not on falling edge"); // RQ5

    property p_crs_on;
        @(posedge clk) disable iff (!rst_n)
        pmd_rx_sos && speed_s2_reg && !crs_reg |-> ##[CRSA_ON:CRSA_ON] crs_reg;
    endproperty
    a_crs_on: assert property (p_crs_on) else $error("carrier sense on delay wrong"); // RQ3

    property p_crs_off;
        @(posedge clk) disable iff (!rst_n)
        pmd_rx_eos && speed_s2_reg && crs_reg && crs_on_cnt_reg == '0 |-> ##[CRSA_OFF:CRSA_OFF] !crs_reg;
    endproperty
    a_crs_off: assert property (p_crs_off) else $error("carrier sense off delay wrong"); // RQ4

    property p_rx_data;
        @(posedge clk) disable iff (!rst_n)
        pmd_rx_valid && speed_s2_reg && !rx_out_valid && !rx_dv_reg && !rx_mode_chg
        |-> ##[RXA_LO:RXA_HI] rx_dv_reg;
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("receive data latency wrong"); // RQ3

    property p_rx_min_phase;
        @(posedge clk) disable iff (!rst_n)
        $changed(rx_clk_reg) |->
            $past(rx_run_reg) + 7'h01 >= ($past(rx_mode_reg[1]) ? mpt_pkg::MIN_HALF100_CYC : mpt_pkg::MIN_HALF10_CYC);
    endproperty
    a_rx_min_phase: assert property (p_rx_min_phase) else $error("receive clock phase too short"); // RQ7

    property p_rx_nibble_edge;
        @(posedge clk) disable iff (!rst_n)
        $changed(rxd_reg) || $changed(rx_dv_reg) |-> $rose(rx_clk_reg);
    endproperty
    a_rx_nibble_edge: assert property (p_rx_nibble_edge) else $error("receive nibble off clock edge"); // RQ10

    c_tx100: cover property (@(posedge clk) disable iff (!rst_n) tx_start && speed_s2_reg ##[1:20] pmd_tx_sos_reg);
    c_tx10:  cover property (@(posedge clk) disable iff (!rst_n) tx_start && !speed_s2_reg ##[1:60] pmd_tx_sos_reg);
    c_crs:   cover property (@(posedge clk) disable iff (!rst_n) $rose(crs_reg) ##[1:400] $fell(crs_reg));
    c_stretch: cover property (@(posedge clk) disable iff (!rst_n) phase_end && rx_mode_chg);
endmodule

// >>> test/mpt_mac_model.sv
`timescale 1ns/1ns
module mpt_mac_model (
    input  wire logic       tx_clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [7:0] count,
    input  wire logic [3:0] base,
    output logic            busy,
    output logic            tx_en,
    output logic [3:0]      txd
);
    logic [7:0] left_reg;
    logic [3:0] nib_reg;

    assign busy = (left_reg != 8'h00) || tx_en;

    // ==========================================================
    // Frame launch on the rising transmit clock edge, one nibble per clock.
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_reg <= 8'h00;
            nib_reg  <= 4'h0;
            tx_en    <= 1'b0;
            txd      <= 4'h0;
        end else if (left_reg != 8'h00) begin
            tx_en    <= 1'b1;
            txd      <= nib_reg;
            nib_reg  <= nib_reg + 4'h1;
            left_reg <= left_reg - 8'h01;
        end else begin
            tx_en <= 1'b0;
            txd   <= ~txd;
            if (go && !tx_en) begin
                left_reg <= count;
                nib_reg  <= base;
            end
        end
    end
endmodule

// >>> test/mpt_mii_pmd_timing_tb.sv
`timescale 1ns/1ns
module mpt_mii_pmd_timing_tb;
    logic       clk = 1'b0;
    logic       rst_n, speed_100, tx_clk, tx_en, pmd_tx_ready, pmd_tx_valid, pmd_tx_sos, pmd_tx_eos;
    logic       tx_fifo_ready, pmd_rx_valid, pmd_rx_sos, pmd_rx_eos, rx_src_recovered, pmd_rx_ready;
    logic       rx_clk, rx_dv, crs, mac_go, mac_busy, en_r, enf_q, crs_q, dv_q, rck_q, saw_full;
    logic       sp_ph, sp_pr, sp_pp;
    logic [3:0] txd, pmd_txd, pmd_rxd, rxd, mac_base;
    logic [7:0] mac_cnt;
    logic [3:0] txq[$];
    logic [3:0] rq[$];
    int         error_cnt, comparisons, cyc, ph;
    int         t_r1, t_f1, t_end, t_sos, t_eos, t_on, t_off, t_dv;

    always #4 clk = ~clk;
    initial begin
        tx_clk = 1'b0;
        #3;
        forever #40 tx_clk = ~tx_clk;
    end

    mpt_mii_pmd_timing i_dut (.clk(clk), .rst_n(rst_n), .speed_100(speed_100), .tx_clk(tx_clk), .tx_en(tx_en),
        .txd(txd), .pmd_tx_ready(pmd_tx_ready), .pmd_tx_valid(pmd_tx_valid), .pmd_txd(pmd_txd),
        .pmd_tx_sos(pmd_tx_sos), .pmd_tx_eos(pmd_tx_eos), .tx_fifo_ready(tx_fifo_ready),
        .pmd_rx_valid(pmd_rx_valid), .pmd_rxd(pmd_rxd), .pmd_rx_sos(pmd_rx_sos), .pmd_rx_eos(pmd_rx_eos),
        .rx_src_recovered(rx_src_recovered), .pmd_rx_ready(pmd_rx_ready), .rx_clk(rx_clk), .rx_dv(rx_dv),
        .rxd(rxd), .crs(crs));
    mpt_mac_model i_mac (.tx_clk(tx_clk), .rst_n(rst_n), .go(mac_go), .count(mac_cnt), .base(mac_base),
        .busy(mac_busy), .tx_en(tx_en), .txd(txd));

    // ==========================================================
    // Monitors of the transmit clock, outputs and receive clock phases.
    always @(posedge tx_clk) begin
        if (tx_en === 1'b1 && en_r === 1'b0) t_r1 = $time;
        if (tx_en === 1'b0 && en_r === 1'b1) t_end = $time;
        en_r = tx_en;
    end
    always @(negedge tx_clk) begin
        if (tx_en === 1'b1 && enf_q === 1'b0) t_f1 = $time;
        enf_q = tx_en;
    end
    always @(negedge rx_clk) if (rx_dv === 1'b1) rq.push_back(rxd);
    always @(posedge clk) begin
        if (pmd_tx_valid === 1'b1) txq.push_back(pmd_txd);
        if (pmd_tx_sos === 1'b1 && t_sos == 0) t_sos = $time - mpt_pkg::CLK_NS;
        if (pmd_tx_eos === 1'b1) t_eos = $time - mpt_pkg::CLK_NS;
        if (tx_fifo_ready === 1'b0) saw_full = 1'b1;
        if (crs === 1'b1 && crs_q === 1'b0) t_on = $time - mpt_pkg::CLK_NS;
        if (crs === 1'b0 && crs_q === 1'b1) t_off = $time - mpt_pkg::CLK_NS;
        if (rx_dv === 1'b1 && dv_q === 1'b0 && t_dv == 0) t_dv = $time - mpt_pkg::CLK_NS;
        crs_q = crs;
        dv_q  = rx_dv;
        if (rst_n !== 1'b1) begin
            ph = 100;
        end else if (rx_clk !== rck_q) begin
            comparisons++;
            if (ph < ((sp_ph || sp_pr || sp_pp) ? mpt_pkg::MIN_HALF100_CYC : mpt_pkg::MIN_HALF10_CYC)) begin
                error_cnt++;
                $display("CHECK FAILED rx_clk_phase expected long phase seen %0d", ph);
            end
            sp_pp = sp_pr;
            sp_pr = sp_ph;
            sp_ph = speed_100;
            ph = 1;
        end else begin
            ph++;
        end
        rck_q = rx_clk;
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            $display("CHECK FAILED timeout expected %0d seen %0d", 9999, cyc);
            end_of_test();
        end
    end

    // ==========================================================
    // Shared comparisons and the closing report.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Transmit frame, optionally with the medium side stalled.
    task automatic tx_frame(input logic sp, input int n, input logic [3:0] base, input logic stall);
        int lat;
        int lim;
        @(posedge clk);
        speed_100    <= sp;
        pmd_tx_ready <= !stall;
        repeat (20) @(posedge clk);
        txq.delete();
        saw_full = 1'b0;
        t_sos    = 0;
        mac_go   <= 1'b1;
        mac_cnt  <= 8'(n);
        mac_base <= base;
        lim = 0;
        while (mac_busy !== 1'b1 && lim < 100) begin
            @(posedge clk);
            lim++;
        end
        mac_go <= 1'b0;
        while (mac_busy === 1'b1 && lim < 3000) begin
            @(posedge clk);
            lim++;
        end
        repeat (80) @(posedge clk);
        if (stall) begin
            chk("tx_fifo_ready_low", 1, saw_full);
            pmd_tx_ready <= 1'b1;
            repeat (300) @(posedge clk);
        end
        chk("tx_nibble_count", stall ? mpt_pkg::FIFO_DEPTH + 1 : n, txq.size());
        foreach (txq[i]) chk("tx_nibble", 4'(base + i), txq[i]);
        lat = sp ? int'(mpt_pkg::TX_LAT100_CYC) : int'(mpt_pkg::TX_LAT10_CYC);
        if (!stall && sp) chk_rng("tx_start_ns", (lat + 2) * 8, (lat + 4) * 8, t_sos - t_r1);
        if (!stall && sp) chk_rng("tx_end_ns", (lat + 2) * 8, (lat + 4) * 8, t_eos - t_end);
        if (!stall && !sp) chk_rng("tx_start_ns", (lat + 2) * 8, (lat + 4) * 8, t_sos - t_f1);
    endtask

    // ==========================================================
    // Receive frame of two nibbles with a clock source switch inside.
    task automatic rx_frame(input logic sp, input int on, input int lo, input int per, input int off);
        int tc0;
        int tc1;
        @(posedge clk);
        speed_100 <= sp;
        repeat (120) @(posedge clk);
        rq.delete();
        t_dv = 0;
        chk("pmd_rx_ready", 1, pmd_rx_ready);
        pmd_rx_sos   <= 1'b1;
        pmd_rx_valid <= 1'b1;
        pmd_rxd      <= 4'hA;
        tc0 = $time;
        @(posedge clk);
        pmd_rx_sos       <= 1'b0;
        pmd_rx_valid     <= 1'b0;
        pmd_rxd          <= 4'h5;
        rx_src_recovered <= 1'b1;
        repeat (2 * per) @(posedge clk);
        pmd_rx_valid     <= 1'b1;
        rx_src_recovered <= 1'b0;
        @(posedge clk);
        pmd_rx_valid <= 1'b0;
        pmd_rxd      <= 4'h0;
        repeat (lo + 3 * per) @(posedge clk);
        pmd_rx_eos <= 1'b1;
        tc1 = $time;
        @(posedge clk);
        pmd_rx_eos <= 1'b0;
        repeat (off + 10) @(posedge clk);
        chk("crs_on_cycles", on, (t_on - tc0) / 8);
        chk_rng("rx_data_cycles", lo, lo + per, (t_dv - tc0) / 8);
        chk("crs_off_cycles", off, (t_off - tc1) / 8);
        chk("rx_nibble_count", 2, rq.size());
        if (rq.size() == 2) chk("rx_nibble_0", 4'hA, rq[0]);
        if (rq.size() == 2) chk("rx_nibble_1", 4'h5, rq[1]);
    endtask

    initial begin
        rst_n = 1'b0;
        speed_100 = 1'b1;
        pmd_tx_ready = 1'b1;
        pmd_rx_valid = 1'b0;
        pmd_rxd = 4'h0;
        pmd_rx_sos = 1'b0;
        pmd_rx_eos = 1'b0;
        rx_src_recovered = 1'b0;
        mac_go = 1'b0;
        mac_cnt = 8'h00;
        mac_base = 4'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        tx_frame(1'b1, 6, 4'h3, 1'b0);
        tx_frame(1'b0, 4, 4'hC, 1'b0);
        tx_frame(1'b1, 22, 4'h0, 1'b1);
        rx_frame(1'b1, mpt_pkg::CRS_ON100_CYC + 1, mpt_pkg::RXD100_CYC + 1,
                 mpt_pkg::HALF_HI100_CYC + mpt_pkg::HALF_LO100_CYC, mpt_pkg::CRS_OFF100_CYC + 1);
        rx_frame(1'b0, mpt_pkg::CRS_ON10_CYC + 1, mpt_pkg::RXD10_CYC + 1,
                 2 * mpt_pkg::HALF10_CYC, mpt_pkg::CRS_OFF10_CYC + 1);
        end_of_test();
    end
endmodule
